/* File: config_control_regs.svh */
/*
  Offsets, field positions, reset values and timing counts of the
  configuration control block.
  Assumes it is included once per compilation unit, before the package.
*/
`ifndef CONFIG_CONTROL_REGS_SVH
`define CONFIG_CONTROL_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------------
`define CFG_ADR_CTRL      8'h00
`define CFG_ADR_STATUS    8'h04
`define CFG_ADR_DATA      8'h08

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CFG_STAT_MODE_LSB 5
`define CFG_STAT_ERR_BIT  8
`define CFG_STAT_DONE_BIT 9
`define CFG_STAT_CNT_LSB  16
`define CFG_LEN_RESET     16'h0010
`define CFG_PREAMBLE      8'h55

// ----------------------------------------------------------------------
// Timing: system clock cycles per half period of the driven strobe
// ----------------------------------------------------------------------
`define CFG_CCLK_HALF     4

`endif

/* File: config_control_pkg.sv */
/*
  Types of the configuration control block: state and mode codes.
  Assumes config_control_regs.svh is compiled alongside it.
*/
`default_nettype none

package config_control_pkg;

  // One-hot controller states
  typedef enum logic [4:0] {
    ST_INIT   = 5'b00001,
    ST_CONFIG = 5'b00010,
    ST_ERROR  = 5'b00100,
    ST_WAIT   = 5'b01000,
    ST_USER   = 5'b10000
  } state_type;

  // Levels on {hi, mid, lo} mode select pins; other codes act as slave serial
  typedef enum logic [2:0] {
    MODE_MASTER_SERIAL   = 3'b000,
    MODE_MASTER_PARALLEL = 3'b001,
    MODE_SYNC_PERIPH     = 3'b010,
    MODE_SLAVE_PARALLEL  = 3'b011,
    MODE_SLAVE_SERIAL    = 3'b111
  } mode_type;

endpackage : config_control_pkg

`default_nettype wire

/* File: config_control_pins.sv */
/*
  Configuration control logic: mode select, strobe, serial/parallel data
  capture, completion handshake, reprogram and global clear handling, with
  a classic Wishbone slave for length, status and last byte.
  Assumes the pad ring resolves the two-way pins from the enables and
  returns the strobe wire level on cclk_link_i in every mode.
*/
// How it works
// R1 - Clear pin low during loading restarts init
// R2 - After loading, clear pin clears user flops
// R3 - Master modes drive strobe, capture data with it
// R4 - Slave modes: source drives strobe with data
// R5 - Completion line released high when loading ends
// R6 - Completion held low delays user I/O enable
// R7 - Completion line is open drain, pulled up
// R8 - Reprogram low abandons state, restarts loading
// R9 - Reprogram low also resets boundary scan
// R10 - Slow reprogram rise: source holds clear low
// R11 - Serial modes take bits on strobe edge
// R12 - Parallel modes use serial pin as bit 0
// R13 - Three mode pins choose loading mode
// R14 - Bad preamble or checksum: error low, init
// R15 - Error flag released when loading resumes
// R16 - Loading: active high and companion low
// R17 - Chained serial out changes on strobe fall
// R18 - Mode latched at start, held while loading
`include "config_control_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module config_control_pins #(
  parameter int unsigned CCLK_HALF = `CFG_CCLK_HALF,
  parameter logic [7:0]  PREAMBLE  = `CFG_PREAMBLE
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [7:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        cclk_link_i,
  output logic                             cclk_o,
  output logic                             cclk_oe_n_o,
  input  wire logic                        din_i,
  input  wire logic [7:0]                  data_i,
  output logic                             dout_o,
  input  wire logic                        done_i,
  output logic                             done_o,
  output logic                             done_oe_n_o,
  output logic                             err_n_o,
  output logic                             err_n_oe_n_o,
  input  wire logic                        prgm_n_i,
  input  wire logic                        global_clr_n_i,
  input  wire logic                        mode_select_hi_i,
  input  wire logic                        mode_select_mid_i,
  input  wire logic                        mode_select_lo_i,
  output logic                             active_hi_o,
  output logic                             active_lo_n_o,
  output logic                             user_io_en_o,
  output logic                             user_clear_o,
  output logic                             jtag_reset_o,
  output config_control_pkg::state_type    state_o
);
  import config_control_pkg::*;

  // ----------------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------------
  function automatic logic is_master(input logic [2:0] m);
    is_master = (m == MODE_MASTER_SERIAL) || (m == MODE_MASTER_PARALLEL);
  endfunction : is_master

  function automatic logic is_parallel(input logic [2:0] m);
    is_parallel = (m == MODE_MASTER_PARALLEL) || (m == MODE_SYNC_PERIPH) ||
                  (m == MODE_SLAVE_PARALLEL);
  endfunction : is_parallel

  // ----------------------------------------------------------------------
  // Pin synchronisers into the system clock
  // ----------------------------------------------------------------------
  logic       prgm_s1_q, prgm_s2_q, clr_s1_q, clr_s2_q, done_s1_q, done_s2_q;
  logic [2:0] mode_s1_q, mode_s2_q;
  logic       tog_s1_q, tog_s2_q, tog_s3_q;
  logic       tog_l_q;
  logic [7:0] byte_l_q;

  // Pins idle high are reset high so no false restart follows reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {prgm_s1_q, prgm_s2_q, clr_s1_q, clr_s2_q} <= 4'hf;
      {done_s1_q, done_s2_q, tog_s1_q, tog_s2_q, tog_s3_q} <= 5'h00;
      {mode_s1_q, mode_s2_q} <= 6'h00;
    end
    else if (ce_i)
    begin
      {prgm_s1_q, prgm_s2_q} <= {prgm_n_i, prgm_s1_q};
      {clr_s1_q, clr_s2_q}   <= {global_clr_n_i, clr_s1_q};
      {done_s1_q, done_s2_q} <= {done_i, done_s1_q};
      mode_s1_q <= {mode_select_hi_i, mode_select_mid_i, mode_select_lo_i};
      mode_s2_q <= mode_s1_q;                          // [R13]
      {tog_s1_q, tog_s2_q, tog_s3_q} <= {tog_l_q, tog_s1_q, tog_s2_q};
    end
  end

  // ----------------------------------------------------------------------
  // Controller state and frame checking
  // ----------------------------------------------------------------------
  state_type   state_q, state_d;
  logic [2:0]  mode_q;
  logic [15:0] len_q, cnt_q;
  logic [7:0]  chk_q, last_q;
  logic        err_flag_q;

  wire         restart    = !prgm_s2_q;                       // [R8]
  wire         both_high  = prgm_s2_q && clr_s2_q;
  // Byte held in the link register stays put for a whole strobe period
  wire         byte_evt   = (tog_s2_q ^ tog_s3_q) && (state_q == ST_CONFIG);
  wire         first_byte = byte_evt && (cnt_q == 16'h0000);
  wire         final_byte = byte_evt && (cnt_q == len_q - 16'h0001);
  wire         bad_pre    = first_byte && (byte_l_q != PREAMBLE);
  wire         bad_sum    = final_byte && !first_byte && (byte_l_q != chk_q);
  wire         start      = (state_q == ST_INIT) && (state_d == ST_CONFIG);
  wire [2:0]   mode_d     = start ? mode_s2_q : mode_q;        // [R18]
  wire         err_flag_d = (state_d == ST_ERROR) ||
                            (err_flag_q && (state_d != ST_CONFIG)); // [R15]

  // Next state; reprogram overrides every other transition
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_INIT:   if (both_high) state_d = ST_CONFIG;
      ST_CONFIG:
      begin
        if (!clr_s2_q)                state_d = ST_INIT;   // [R1]
        else if (bad_pre || bad_sum)  state_d = ST_ERROR;  // [R14]
        else if (final_byte)          state_d = ST_WAIT;
      end
      ST_ERROR:  if (!clr_s2_q) state_d = ST_INIT;        // [R14]
      ST_WAIT:   if (done_s2_q) state_d = ST_USER;        // [R6]
      ST_USER:   state_d = ST_USER;
      default:   state_d = ST_INIT;
    endcase
    if (restart)
      state_d = ST_INIT;                                  // [R8]
  end

  // State, mode latch, byte count and running checksum
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q    <= ST_INIT;
      mode_q     <= 3'h0;
      cnt_q      <= 16'h0000;
      chk_q      <= 8'h00;
      last_q     <= 8'h00;
      err_flag_q <= 1'b0;
    end
    else if (ce_i)
    begin
      state_q    <= state_d;
      mode_q     <= mode_d;
      err_flag_q <= err_flag_d;
      if (start)
      begin
        cnt_q <= 16'h0000;
        chk_q <= 8'h00;
      end
      else if (byte_evt)
      begin
        cnt_q  <= cnt_q + 16'h0001;
        chk_q  <= first_byte ? 8'h00 : (chk_q ^ byte_l_q);
        last_q <= byte_l_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin enables registered from next-state values; open-drain levels tied low
  // ----------------------------------------------------------------------
  localparam int unsigned DIV_W = $clog2(CCLK_HALF + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CCLK_HALF - 1);
  logic [DIV_W-1:0] div_q;
  logic             arm_q;

  wire drive_cclk = (state_d == ST_CONFIG) && is_master(mode_d);
  wire released   = (state_d == ST_WAIT) || (state_d == ST_USER);

  // Open-drain lines only ever pull low; the pull-up gives the high
  assign done_o  = 1'b0;                                  // [R7]
  assign err_n_o = 1'b0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {cclk_o, cclk_oe_n_o, done_oe_n_o, err_n_oe_n_o} <= 4'h7;
      {active_hi_o, active_lo_n_o} <= 2'h1;
      {user_io_en_o, user_clear_o, jtag_reset_o, arm_q} <= 4'h0;
      div_q   <= '0;
      state_o <= ST_INIT;
    end
    else if (ce_i)
    begin
      cclk_oe_n_o   <= !drive_cclk;                       // [R3]
      done_oe_n_o   <= released;                          // [R5] [R7]
      err_n_oe_n_o  <= !err_flag_d;                       // [R14]
      active_hi_o   <= (state_d == ST_CONFIG);            // [R16]
      active_lo_n_o <= (state_d != ST_CONFIG);            // [R16]
      user_io_en_o  <= (state_d == ST_USER);              // [R6]
      user_clear_o  <= (state_d == ST_USER) && !clr_s2_q; // [R2]
      jtag_reset_o  <= restart;                           // [R9]
      arm_q         <= (state_d == ST_CONFIG);
      state_o       <= state_d;
      // Strobe divider: runs only while driving, parks low otherwise
      if (!drive_cclk)
      begin
        div_q  <= '0;
        cclk_o <= 1'b0;
      end
      else if (div_q == DIV_LAST)
      begin
        div_q  <= '0;
        cclk_o <= !cclk_o;                                // [R3]
      end
      else
        div_q <= div_q + DIV_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // Link logic on the strobe wire
  // ----------------------------------------------------------------------
  // The strobe stands still outside frames, so the arm level needs two
  // strobe edges to arrive; those lead-in edges capture nothing.
  logic       arm_l1_q, arm_l2_q, din_l_q, dout_q;
  logic [2:0] mode_l1_q, mode_l2_q, bit_l_q;
  logic [6:0] shift_l_q;

  wire        par_l  = is_parallel(mode_l2_q);
  // No strobe edge follows a frame, so the arm level is dropped at once
  // when loading stops; a stale arm would capture the next lead-in
  wire        disarm = rst_i || !arm_q;

  // Arm level: cleared at once, raised through two strobe edges
  always_ff @(posedge cclk_link_i or posedge disarm)
  begin
    if (disarm)
      {arm_l1_q, arm_l2_q} <= 2'h0;
    else
      {arm_l1_q, arm_l2_q} <= {arm_q, arm_l1_q};
  end

  always_ff @(posedge cclk_link_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {din_l_q, tog_l_q} <= 2'h0;
      {mode_l1_q, mode_l2_q, bit_l_q} <= 9'h000;
      shift_l_q <= 7'h00;
      byte_l_q  <= 8'h00;
    end
    else
    begin
      {mode_l1_q, mode_l2_q} <= {mode_q, mode_l1_q};      // static in frame
      din_l_q <= din_i;
      if (!arm_l2_q)
        bit_l_q <= 3'h0;
      else if (par_l)
      begin
        byte_l_q <= {data_i[7:1], din_i};                 // [R12] [R4]
        tog_l_q  <= !tog_l_q;
      end
      else
      begin
        shift_l_q <= {shift_l_q[5:0], din_i};             // [R11]
        bit_l_q   <= bit_l_q + 3'h1;
        if (bit_l_q == 3'h7)
        begin
          byte_l_q <= {shift_l_q, din_i};                 // [R11]
          tog_l_q  <= !tog_l_q;
        end
      end
    end
  end

  // Chained serial data leaves on the falling strobe edge
  always_ff @(negedge cclk_link_i or posedge rst_i)
  begin
    if (rst_i)
      dout_q <= 1'b0;
    else
      dout_q <= arm_l2_q && din_l_q;                      // [R17]
  end
  assign dout_o = dout_q;

  // ----------------------------------------------------------------------
  // Wishbone slave: one wait state, unmapped reads give zero
  // ----------------------------------------------------------------------
  wire        wb_req  = wb_cyc_i && wb_stb_i;
  wire [7:0]  wb_word = {wb_adr_i[7:2], 2'b00};
  wire        sel_ctl = (wb_word == `CFG_ADR_CTRL);
  wire [31:0] status  = {cnt_q, 6'h00, done_s2_q, err_flag_q, mode_q, state_q};
  wire [31:0] rd_data = sel_ctl ? {16'h0000, len_q} :
                        (wb_word == `CFG_ADR_STATUS) ? status :
                        (wb_word == `CFG_ADR_DATA) ? {24'h000000, last_q} :
                        32'h00000000;

  // Write lands on the edge where the master sees ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      len_q    <= `CFG_LEN_RESET;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_req && !wb_ack_o;
      wb_dat_o <= rd_data;
      if (wb_req && wb_ack_o && wb_we_i && sel_ctl)
      begin
        if (wb_sel_i[0]) len_q[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) len_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_resume;
    (state_q == ST_INIT) ##1 (state_q == ST_CONFIG);
  endsequence

  property p_clear_init;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == ST_CONFIG && !clr_s2_q && ce_i) |=> (state_q == ST_INIT);
  endproperty
  a_clear_init: assert property (p_clear_init)  // [R1]
    else $error("clear during loading did not restart init");

  property p_user_clear;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == ST_USER && !clr_s2_q && prgm_s2_q && ce_i) |=> user_clear_o;
  endproperty
  a_user_clear: assert property (p_user_clear)  // [R2]
    else $error("user clear missing after loading");

  property p_master_drive;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == ST_CONFIG && is_master(mode_q)) |-> !cclk_oe_n_o;
  endproperty
  a_master_drive: assert property (p_master_drive)  // [R3]
    else $error("strobe not driven in master mode");

  property p_done_release;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == ST_CONFIG) |-> !done_oe_n_o ##1 (state_q != ST_WAIT ||
                                                 done_oe_n_o);
  endproperty
  a_done_release: assert property (p_done_release)  // [R5]
    else $error("completion line wrongly driven");

  property p_user_wait;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == ST_WAIT && !done_s2_q && prgm_s2_q) |=>
      (state_q == ST_WAIT) && !user_io_en_o;
  endproperty
  a_user_wait: assert property (p_user_wait)  // [R6]
    else $error("user I/O enabled while completion held low");

  property p_prgm_restart;
    @(posedge clk_i) disable iff (rst_i)
    (!prgm_s2_q && ce_i) |=> (state_q == ST_INIT) && jtag_reset_o;
  endproperty
  a_prgm_restart: assert property (p_prgm_restart)  // [R8]
    else $error("reprogram did not restart and reset scan");

  property p_err_low;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == ST_ERROR) |-> !err_n_oe_n_o;
  endproperty
  a_err_low: assert property (p_err_low)  // [R14]
    else $error("error flag not driven low");

  property p_err_release;
    @(posedge clk_i) disable iff (rst_i)
    s_resume |-> err_n_oe_n_o && active_hi_o;
  endproperty
  a_err_release: assert property (p_err_release)  // [R15]
    else $error("error flag held after loading resumed");

  property p_active_ind;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == ST_CONFIG) |-> active_hi_o && !active_lo_n_o;
  endproperty
  a_active_ind: assert property (p_active_ind)  // [R16]
    else $error("activity indicators wrong during loading");

  property p_mode_hold;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == ST_CONFIG) ##1 (state_q == ST_CONFIG) |-> $stable(mode_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold)  // [R18]
    else $error("mode changed during loading");

  property p_serial_byte;
    @(posedge cclk_link_i) disable iff (rst_i || !arm_l2_q)
    (!par_l && bit_l_q == 3'h7) |=> (tog_l_q != $past(tog_l_q));
  endproperty
  a_serial_byte: assert property (p_serial_byte)  // [R11]
    else $error("eighth serial bit did not complete a byte");

  property p_par_bit0;
    @(posedge cclk_link_i) disable iff (rst_i || !arm_l2_q)
    par_l |=> (byte_l_q[0] == $past(din_i));
  endproperty
  a_par_bit0: assert property (p_par_bit0)  // [R12]
    else $error("parallel bit 0 not from serial pin");

endmodule : config_control_pins

`default_nettype wire

/* File: config_source.sv */
/*
  Model of the configuration source on the far side: strobe, serial bit
  and data byte, as a slave-mode memory or host would drive them.
  Assumes the bench resolves the strobe wire and calls its tasks.
*/
`timescale 1ns/1ps
`default_nettype none

module config_source (
  output var logic       strobe_o,
  output var logic       din_o,
  output var logic [7:0] data_o
);

  // Strobe stands still low between frames
  initial
  begin
    strobe_o = 1'b0;
    din_o    = 1'b0;
    data_o   = 8'h00;
  end

  // One pulse at the 12 ns link period; data was set before the rise
  task pulse();
    #6 strobe_o = 1'b1;
    #6 strobe_o = 1'b0;
  endtask : pulse

  // Two lead-in strobes let the arm level cross into the link domain
  task lead_in();
    #3;
    pulse();
    pulse();
  endtask : lead_in

  // MSB first; the gap keeps byte spacing above 100 ns
  task send_serial(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      din_o = b[i];
      pulse();
    end
    #60 din_o = ~din_o; // released line must not hold the last bit
  endtask : send_serial

  // One byte per strobe, bit zero travels on the serial line
  task send_parallel(input logic [7:0] d, input logic b0);
    data_o = d;
    din_o  = b0;
    pulse();
    #110 data_o = ~data_o;
    din_o = ~din_o;
  endtask : send_parallel

endmodule : config_source

`default_nettype wire

/* File: config_control_pins_bench.sv */
/*
  Self-checking bench for the configuration control block.
  Assumes the design files and config_source.sv are compiled first.
*/
`include "config_control_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module config_control_pins_bench;
  import config_control_pkg::*;

  logic        clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i, src_data;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        wb_ack_o, cclk_o, cclk_oe_n_o, dout_o, done_o, done_oe_n_o;
  logic        err_n_o, err_n_oe_n_o, prgm_n_i, global_clr_n_i, hold_low;
  logic        active_hi_o, active_lo_n_o, user_io_en_o, user_clear_o;
  logic        jtag_reset_o, src_strobe, src_din;
  logic [2:0]  mode;
  state_type   state_o;
  int          n_fail, checks;
  // Pad resolution: strobe by direction, completion wired with pull-up
  wire cclk_wire = cclk_oe_n_o ? src_strobe : cclk_o;
  wire done_wire = (done_oe_n_o ? 1'b1 : done_o) & ~hold_low;

  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  config_control_pins #(.CCLK_HALF(2)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cclk_link_i(cclk_wire), .cclk_o(cclk_o),
    .cclk_oe_n_o(cclk_oe_n_o), .din_i(src_din), .data_i(src_data),
    .dout_o(dout_o), .done_i(done_wire), .done_o(done_o),
    .done_oe_n_o(done_oe_n_o), .err_n_o(err_n_o),
    .err_n_oe_n_o(err_n_oe_n_o), .prgm_n_i(prgm_n_i),
    .global_clr_n_i(global_clr_n_i), .mode_select_hi_i(mode[2]),
    .mode_select_mid_i(mode[1]), .mode_select_lo_i(mode[0]),
    .active_hi_o(active_hi_o), .active_lo_n_o(active_lo_n_o),
    .user_io_en_o(user_io_en_o), .user_clear_o(user_clear_o),
    .jtag_reset_o(jtag_reset_o), .state_o(state_o));

  config_source src (
    .strobe_o(src_strobe), .din_o(src_din), .data_o(src_data));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // Classic cycle: hold everything until ack is seen at an edge
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_sel_i <= 4'hf;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n++ < 20);
    if (wb_ack_o !== 1'b1)
      n_fail++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // Bounded wait on the state, then compare it
  task wait_st(input state_type s);
    int n;
    n = 0;
    while (state_o !== s && n++ < 60)
      @(posedge clk_i);
    check(32'(state_o), 32'(s));
  endtask : wait_st

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_reset();
    wait_st(ST_INIT);
    cyc(4);
    check(32'({active_hi_o, active_lo_n_o, done_oe_n_o, jtag_reset_o}),
          32'h5);
    wb(1'b0, `CFG_ADR_CTRL, 32'h0);
    check(rd, 32'h10);
    wb(1'b1, `CFG_ADR_CTRL, 32'h4);
    wb(1'b1, `CFG_ADR_STATUS, 32'hffff_ffff); // read-only, ignored
    wb(1'b0, `CFG_ADR_CTRL, 32'h0);
    check(rd, 32'h4);
    wb(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h0);
  endtask : t_reset

  // Serial frame with completion held low by a chained device
  task t_serial();
    prgm_n_i <= 1'b1;
    wait_st(ST_CONFIG);
    mode <= 3'b000; // pins move mid-load; the latched mode must not
    cyc(4);
    check(32'({active_hi_o, active_lo_n_o, cclk_oe_n_o}), 32'h5);
    wb(1'b0, `CFG_ADR_STATUS, 32'h0);
    check(32'(rd[7:0]), 32'he2);
    hold_low <= 1'b1;
    src.lead_in();
    src.send_serial(8'h55);
    src.send_serial(8'ha5);
    check(32'(dout_o), 32'h1);
    src.send_serial(8'h3c);
    check(32'(dout_o), 32'h0);
    src.send_serial(8'h99);
    wait_st(ST_WAIT);
    cyc(20);
    check(32'({done_oe_n_o, user_io_en_o}), 32'h2);
    hold_low <= 1'b0;
    wait_st(ST_USER);
    check(32'(user_io_en_o), 32'h1);
    wb(1'b0, `CFG_ADR_DATA, 32'h0);
    check(rd, 32'h99);
  endtask : t_serial

  task t_clear();
    ce_i <= 1'b0; // frozen core must not see the clear pin
    global_clr_n_i <= 1'b0;
    cyc(5);
    check(32'({user_clear_o, user_io_en_o}), 32'h1);
    ce_i <= 1'b1;
    cyc(5);
    check(32'({user_clear_o, user_io_en_o}), 32'h3);
    global_clr_n_i <= 1'b1;
    cyc(5);
    check(32'({user_clear_o, user_io_en_o}), 32'h1);
  endtask : t_clear

  task t_reprog();
    mode <= 3'b011;
    prgm_n_i <= 1'b0;
    wait_st(ST_INIT);
    cyc(2);
    check(32'({jtag_reset_o, user_io_en_o, done_oe_n_o}), 32'h4);
    wb(1'b1, `CFG_ADR_CTRL, 32'h3);
  endtask : t_reprog

  // Bad preamble, recovery, then a parallel frame using the serial pin
  task t_error();
    prgm_n_i <= 1'b1;
    wait_st(ST_CONFIG);
    src.lead_in();
    src.send_parallel(8'h54, 1'b0);
    wait_st(ST_ERROR);
    check(32'(err_n_oe_n_o), 32'h0);
    mode <= 3'b010; // resume in synchronous peripheral mode
    global_clr_n_i <= 1'b0;
    wait_st(ST_INIT);
    global_clr_n_i <= 1'b1;
    wait_st(ST_CONFIG);
    cyc(2);
    check(32'(err_n_oe_n_o), 32'h1);
    src.lead_in();
    src.send_parallel(8'h54, 1'b1);
    src.send_parallel(8'h80, 1'b1);
    src.send_parallel(8'h80, 1'b1);
    wait_st(ST_USER);
    wb(1'b0, `CFG_ADR_STATUS, 32'h0);
    check(32'(rd[7:0]), 32'h50);
    wb(1'b0, `CFG_ADR_DATA, 32'h0);
    check(rd, 32'h81);
  endtask : t_error

  // Master serial strobe, clear pin held across the reprogram rise
  task t_master();
    int   n;
    logic prev;
    mode <= 3'b000;
    prgm_n_i <= 1'b0;
    global_clr_n_i <= 1'b0;
    wait_st(ST_INIT);
    prgm_n_i <= 1'b1;
    cyc(8);
    check(32'(state_o), 32'(ST_INIT));
    global_clr_n_i <= 1'b1;
    wait_st(ST_CONFIG);
    cyc(3);
    n = 0;
    prev = cclk_o;
    repeat (16)
    begin
      @(posedge clk_i);
      if (cclk_o !== prev)
        n++;
      prev = cclk_o;
    end
    check(32'(n), 32'h8);
    check(32'(cclk_oe_n_o), 32'h0);
    global_clr_n_i <= 1'b0;
    wait_st(ST_INIT);
    cyc(2);
    check(32'({cclk_oe_n_o, active_hi_o}), 32'h2);
  endtask : t_master

  // Main sequence
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    ce_i = 1'b1;
    rst_i = 1'b1;
    prgm_n_i = 1'b0;
    global_clr_n_i = 1'b1;
    mode = 3'b111;
    hold_low = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_serial();
    t_clear();
    t_reprog();
    t_error();
    t_master();
    conclude();
  end

  // Watchdog: the run needs well under 5000 cycles
  initial
  begin
    #100000;
    n_fail++;
    conclude();
  end

endmodule : config_control_pins_bench

`default_nettype wire
